// >>> eeprom_pkg.sv
// Shared constants, types and state codes for the serial EEPROM instruction block
package eeprom_pkg;

  // ==========================================================
  // Instruction codes, first byte after select falls
  localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
  localparam logic [7:0] CMD_ARRAY_WRITE = 8'h02;
  localparam logic [7:0] CMD_ARRAY_READ = 8'h03;
  localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] CMD_STATUS_READ = 8'h05;
  localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
  // Seven leading bits shared by the disable and status read codes
  localparam logic [6:0] CMD_STATUS_READ_HEAD = 7'h02;

  // ==========================================================
  // Status register bit positions
  localparam int SR_SWD_BIT = 7;
  localparam int SR_BP_HI_BIT = 3;
  localparam int SR_BP_LO_BIT = 2;
  localparam int SR_WEL_BIT = 1;
  localparam int SR_WIP_BIT = 0;
  localparam logic SWD_RESET = 1'b0;
  localparam logic [1:0] BP_RESET = 2'h0;

  // ==========================================================
  // Array geometry and protected zone bases
  localparam int ADDR_W = 17;
  localparam int PAGE_BYTES = 256;
  localparam int ADDR_BYTES = 3;
  localparam logic [16:0] BP_QUARTER_BASE = 17'h1_8000;
  localparam logic [16:0] BP_HALF_BASE = 17'h1_0000;
  localparam logic [7:0] ERASED_BYTE = 8'h00;

  // ==========================================================
  // Self-timed cycle lengths, least times rounded up to clocks
  localparam int CLK_PERIOD_NS = 10;
  localparam int STATUS_CYCLE_TIME_NS = 5_000_000;
  localparam int ARRAY_WRITE_CYCLE_TIME_NS = 5_000_000;
  localparam int STATUS_CYCLE_COUNT = (STATUS_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ARRAY_WRITE_CYCLE_COUNT = (ARRAY_WRITE_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 24;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic en;
    logic [7:0] data;
  } slot_t;

  typedef struct packed {
    logic we;
    logic [16:0] addr;
    logic [7:0] wdata;
  } mem_req_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_CMD = 4'h1,
    ST_ADDR = 4'h2,
    ST_RDATA = 4'h3,
    ST_WDATA = 4'h4,
    ST_SDATA = 4'h5,
    ST_SFULL = 4'h6,
    ST_SREAD = 4'h7,
    ST_WEN = 4'h8,
    ST_WDIS = 4'h9,
    ST_IGNORE = 4'hA
  } state_t;

endpackage

// >>> spi_eeprom_ctrl.sv
// Serial EEPROM instruction engine: status write, array read and page write with protection
`timescale 1ns/1ps

// Function
// - Status write needs the enable latch set
// - Bits 6,5,4,1,0 untouched; 6..4 read zero
// - Select must rise right after last bit
// - Valid status write starts cycle, busy flag
// - Status reads still served during cycle
// - Cycle end clears the enable latch
// - Disable bit low: pin level irrelevant
// - Disable bit high, pin low rejects write
// - Old protection values hold until completion
// - Hardware protection whichever condition came first
// - Only raising pin leaves hardware protection
// - Read loads 17 address bits, upper ignored
// - Read address increments after each byte
// - Read address wraps from top to zero
// - Read ends at any select rise
// - Read ignored while a write cycle runs
// - Array write ends on byte boundary, timed
// - Page write wraps within 256 byte page
// - Array write rejected on five conditions
// - Array cycle erases then programs bytes
// - Instruction codes 01, 03 and 02
// - Block protect codes select protected zone
module spi_eeprom_ctrl #(
  parameter int STATUS_CYCLES = eeprom_pkg::STATUS_CYCLE_COUNT,
  parameter int ARRAY_CYCLES = eeprom_pkg::ARRAY_WRITE_CYCLE_COUNT
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic spi_clk_in,
  input wire logic cs_n_in,
  input wire logic mosi_in,
  input wire logic wp_n_in,
  input wire logic [7:0] mem_rdata_in,
  output logic miso_out,
  output logic miso_oe_out,
  output eeprom_pkg::mem_req_t mem_req_out,
  output logic [7:0] status_out,
  output logic hw_protected_out
);
  import eeprom_pkg::*;

  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  // ==========================================================
  // Link domain: shifter on the serial clock
  logic link_rst;
  logic [2:0] bit_cnt_r;
  logic got_byte_r;
  logic [6:0] shift_r;
  logic [7:0] byte_r;
  logic [6:0] part_r;
  logic byte_tgl_r;
  logic part_tgl_r;
  logic aligned_r;
  logic [7:0] tx_r;
  logic tx_oe_r;
  slot_t slot0_r;
  slot_t slot1_r;
  slot_t slot_pick;

  // Deselect clears the framing, so a read stops at any bit position
  assign link_rst = cs_n_in | ~rst_n_in;

  // Bit counter lives only inside a frame
  always_ff @(posedge spi_clk_in or posedge link_rst) begin
    if (link_rst) begin
      bit_cnt_r <= 3'h0;
      got_byte_r <= 1'b0;
    end else begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      if (bit_cnt_r == 3'h7) begin
        got_byte_r <= 1'b1;
      end
    end
  end

  // Input sampled on rising edges; toggles survive deselect so no false events
  always_ff @(posedge spi_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shift_r <= 7'h00;
      byte_r <= 8'h00;
      part_r <= 7'h00;
      byte_tgl_r <= 1'b0;
      part_tgl_r <= 1'b0;
      aligned_r <= 1'b0;
    end else begin
      shift_r <= {shift_r[5:0], mosi_in};
      aligned_r <= (bit_cnt_r == 3'h7);
      if (bit_cnt_r == 3'h6) begin
        part_r <= {shift_r[5:0], mosi_in};
        part_tgl_r <= ~part_tgl_r;
      end
      if (bit_cnt_r == 3'h7) begin
        byte_r <= {shift_r, mosi_in};
        byte_tgl_r <= ~byte_tgl_r;
      end
    end
  end

  // The last bit of a byte picks between the two prefetched candidates
  assign slot_pick = byte_r[0] ? slot1_r : slot0_r;

  // Output shifts on falling edges; slots were settled a bit-time earlier
  always_ff @(negedge spi_clk_in or posedge link_rst) begin
    if (link_rst) begin
      tx_r <= 8'h00;
      tx_oe_r <= 1'b0;
    end else if (bit_cnt_r == 3'h0 && got_byte_r) begin
      tx_r <= slot_pick.data;
      tx_oe_r <= slot_pick.en;
    end else begin
      tx_r <= {tx_r[6:0], 1'b0};
    end
  end

  assign miso_out = tx_r[7];
  assign miso_oe_out = tx_oe_r;

  // ==========================================================
  // Crossings into the system clock
  logic [3:0] cs_q;
  logic [1:0] wp_q;
  logic [1:0] al_q;
  logic [2:0] bt_q;
  logic [2:0] pt_q;

  // Select runs one stage deeper so the final byte is seen before the rise
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cs_q <= 4'hF;
      wp_q <= 2'h3;
      al_q <= 2'h0;
      bt_q <= 3'h0;
      pt_q <= 3'h0;
    end else begin
      cs_q <= {cs_q[2:0], cs_n_in};
      wp_q <= {wp_q[0], wp_n_in};
      al_q <= {al_q[0], aligned_r};
      bt_q <= {bt_q[1:0], byte_tgl_r};
      pt_q <= {pt_q[1:0], part_tgl_r};
    end
  end

  logic cs_fall;
  logic cs_rise;
  logic byte_ev;
  logic part_ev;
  logic aligned;
  logic hardware_protected_mode;
  assign cs_fall = cs_q[3] & ~cs_q[2];
  assign cs_rise = ~cs_q[3] & cs_q[2];
  assign byte_ev = bt_q[2] ^ bt_q[1];
  assign part_ev = pt_q[2] ^ pt_q[1];
  assign aligned = al_q[1];

  // ==========================================================
  // Status register and protection decode
  logic swd_r;
  logic [1:0] bp_r;
  logic wel_r;
  logic busy_r;
  logic [7:0] status_word;
  logic zone_hit;
  logic page_protected;
  logic [16:0] addr_r;

  // Pin-low and disable-bit combine live, so either order enters protection
  assign hardware_protected_mode = swd_r & ~wp_q[1];

  // Unused positions are tied low
  always_comb begin
    status_word = 8'h00;
    status_word[SR_SWD_BIT] = swd_r;
    status_word[SR_BP_HI_BIT] = bp_r[1];
    status_word[SR_BP_LO_BIT] = bp_r[0];
    status_word[SR_WEL_BIT] = wel_r;
    status_word[SR_WIP_BIT] = busy_r;
  end

  // Zone lookup uses the page base of the addressed bytes
  assign zone_hit = (bp_r == 2'h3)
                  || (bp_r == 2'h2 && {addr_r[16:8], 8'h00} >= BP_HALF_BASE)
                  || (bp_r == 2'h1 && {addr_r[16:8], 8'h00} >= BP_QUARTER_BASE);
  assign page_protected = zone_hit;

  // ==========================================================
  // Instruction state machine
  state_t state_r;
  state_t state_nxt;
  state_t cmd_state;
  logic [1:0] cnt_r;
  logic is_wr_r;

  // Unknown codes drop into the ignore state until deselect
  assign cmd_state = (byte_r == CMD_WRITE_ENABLE) ? ST_WEN :
                     (byte_r == CMD_WRITE_DISABLE) ? ST_WDIS :
                     (byte_r == CMD_STATUS_READ) ? ST_SREAD :
                     (byte_r == CMD_STATUS_WRITE) ? ((wel_r && !busy_r && !hardware_protected_mode) ? ST_SDATA : ST_IGNORE) :
                     (byte_r == CMD_ARRAY_READ) ? (busy_r ? ST_IGNORE : ST_ADDR) :
                     (byte_r == CMD_ARRAY_WRITE) ? ((wel_r && !busy_r) ? ST_ADDR : ST_IGNORE) : ST_IGNORE;

  always_comb begin
    state_nxt = state_r;
    if (cs_fall) begin
      state_nxt = ST_CMD;
    end else if (cs_rise) begin
      state_nxt = ST_IDLE;
    end else if (byte_ev) begin
      case (state_r)
        ST_CMD: state_nxt = cmd_state;
        ST_ADDR: state_nxt = (cnt_r == 2'(ADDR_BYTES - 1)) ? (is_wr_r ? ST_WDATA : ST_RDATA) : ST_ADDR;
        ST_SDATA: state_nxt = ST_SFULL;
        ST_SFULL: state_nxt = ST_IGNORE;
        ST_WEN: state_nxt = ST_IGNORE;
        ST_WDIS: state_nxt = ST_IGNORE;
        default: state_nxt = state_r;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // Address, data capture and page buffer
  logic [7:0] sr_new_r;
  logic [16:0] cur_r;
  logic [7:0] idx_r;
  logic got_data_r;
  logic wbyte;
  logic wr_accept;
  logic [7:0] page_buf_r [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] page_mask_r;
  logic [16:0] next_addr;

  assign wbyte = byte_ev && state_r == ST_WDATA;
  assign wr_accept = byte_ev && state_r == ST_CMD && cmd_state == ST_ADDR && byte_r == CMD_ARRAY_WRITE;
  assign next_addr = cur_r + 17'h0_0001;

  // Upper address bits fall off the 17-bit shifter
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_r <= 2'h0;
      addr_r <= 17'h0_0000;
      is_wr_r <= 1'b0;
      sr_new_r <= 8'h00;
      cur_r <= 17'h0_0000;
      idx_r <= 8'h00;
      got_data_r <= 1'b0;
    end else if (cs_fall) begin
      cnt_r <= 2'h0;
      got_data_r <= 1'b0;
    end else if (byte_ev) begin
      if (state_r == ST_CMD) begin
        is_wr_r <= (byte_r == CMD_ARRAY_WRITE);
      end
      if (state_r == ST_ADDR) begin
        cnt_r <= cnt_r + 2'h1;
        addr_r <= {addr_r[8:0], byte_r};
        cur_r <= {addr_r[8:0], byte_r};
        idx_r <= byte_r;
      end
      if (state_r == ST_SDATA) begin
        sr_new_r <= byte_r;
      end
      if (state_r == ST_RDATA) begin
        cur_r <= next_addr;
      end
      if (state_r == ST_WDATA) begin
        idx_r <= idx_r + 8'h01;
        got_data_r <= 1'b1;
      end
    end
  end

  // Data storage needs no reset; the mask says which entries are live
  always_ff @(posedge clock_in) begin
    if (wbyte) begin
      page_buf_r[idx_r] <= byte_r;
    end
  end

  // Each entry is marked on its own write and wiped when a write is accepted
  for (genvar i = 0; i < PAGE_BYTES; i++) begin : g_mask
    always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        page_mask_r[i] <= 1'b0;
      end else if (wbyte && idx_r == 8'(i)) begin
        page_mask_r[i] <= 1'b1;
      end else if (wr_accept) begin
        page_mask_r[i] <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Commit decisions on deselect
  logic write_enable_instr_go;
  logic wrdi_go;
  logic sw_go;
  logic aw_go;
  assign write_enable_instr_go = cs_rise && aligned && state_r == ST_WEN;
  assign wrdi_go = cs_rise && aligned && state_r == ST_WDIS;
  // Pin is rechecked at the rise in case it fell during the frame
  assign sw_go = cs_rise && aligned && state_r == ST_SFULL && wel_r && !busy_r && !hardware_protected_mode;
  assign aw_go = cs_rise && aligned && state_r == ST_WDATA && got_data_r
               && wel_r && !busy_r && !page_protected;

  // ==========================================================
  // Self-timed cycle: timer plus erase then program walk
  logic kind_arr_r;
  logic [TIMER_W-1:0] timer_r;
  logic [9:0] walk_r;
  logic walking;
  logic done;
  assign walking = busy_r && kind_arr_r && !walk_r[9];
  assign done = busy_r && timer_r == '0 && !walking;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_r <= 1'b0;
      kind_arr_r <= 1'b0;
      timer_r <= '0;
      walk_r <= 10'h000;
    end else if (sw_go || aw_go) begin
      busy_r <= 1'b1;
      kind_arr_r <= aw_go;
      timer_r <= aw_go ? TIMER_W'(ARRAY_CYCLES - 1) : TIMER_W'(STATUS_CYCLES - 1);
      walk_r <= 10'h000;
    end else if (done) begin
      busy_r <= 1'b0;
    end else if (busy_r) begin
      timer_r <= (timer_r == '0) ? timer_r : timer_r - TIMER_W'(1);
      walk_r <= walking ? walk_r + 10'h001 : walk_r;
    end
  end

  // Latch sets win over completion; new protection lands only at completion
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wel_r <= 1'b0;
      swd_r <= SWD_RESET;
      bp_r <= BP_RESET;
    end else begin
      if (write_enable_instr_go) begin
        wel_r <= 1'b1;
      end else if (done || wrdi_go) begin
        wel_r <= 1'b0;
      end
      if (done && !kind_arr_r) begin
        swd_r <= sr_new_r[SR_SWD_BIT];
        bp_r <= {sr_new_r[SR_BP_HI_BIT], sr_new_r[SR_BP_LO_BIT]};
      end
    end
  end

  // ==========================================================
  // Memory port and read prefetch
  mem_req_t mem_r;
  mem_req_t mem_nxt;
  logic [1:0] rd_step_r;
  logic pf_go;
  logic st_go;
  logic [16:0] pf_lo;
  logic [16:0] pf_hi;
  logic [16:0] pf_hi_r;

  // Seven bits of the last address byte give both candidates ahead of time
  assign pf_go = part_ev && ((state_r == ST_ADDR && cnt_r == 2'(ADDR_BYTES - 1) && !is_wr_r) || state_r == ST_RDATA);
  assign st_go = part_ev && ((state_r == ST_CMD && part_r == CMD_STATUS_READ_HEAD) || state_r == ST_SREAD);
  assign pf_lo = (state_r == ST_ADDR) ? {addr_r[8:0], part_r, 1'b0} : next_addr;
  assign pf_hi = (state_r == ST_ADDR) ? {addr_r[8:0], part_r, 1'b1} : next_addr;

  // Writes and reads never overlap since reads are refused while busy
  always_comb begin
    mem_nxt = mem_r;
    mem_nxt.we = 1'b0;
    if (walking) begin
      mem_nxt.we = page_mask_r[walk_r[7:0]];
      mem_nxt.addr = {addr_r[16:8], walk_r[7:0]};
      mem_nxt.wdata = walk_r[8] ? page_buf_r[walk_r[7:0]] : ERASED_BYTE;
    end else if (pf_go) begin
      mem_nxt.addr = pf_lo;
    end else if (rd_step_r == 2'h1) begin
      mem_nxt.addr = pf_hi_r;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mem_r <= '0;
      rd_step_r <= 2'h0;
      pf_hi_r <= 17'h0_0000;
      slot0_r <= '0;
      slot1_r <= '0;
    end else begin
      mem_r <= mem_nxt;
      rd_step_r <= pf_go ? 2'h1 : (rd_step_r == 2'h1) ? 2'h2 : 2'h0;
      if (pf_go) begin
        pf_hi_r <= pf_hi;
      end
      if (cs_rise || (part_ev && !pf_go && !st_go)) begin
        slot0_r.en <= 1'b0;
        slot1_r.en <= 1'b0;
      end else if (st_go) begin
        slot0_r <= '{en: state_r == ST_SREAD, data: status_word};
        slot1_r <= '{en: 1'b1, data: status_word};
      end else if (rd_step_r == 2'h1) begin
        slot0_r <= '{en: 1'b1, data: mem_rdata_in};
      end else if (rd_step_r == 2'h2) begin
        slot1_r <= '{en: 1'b1, data: mem_rdata_in};
      end
    end
  end

  assign mem_req_out = mem_r;

  // Registered views of status and protection
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_out <= 8'h00;
      hw_protected_out <= 1'b0;
    end else begin
      status_out <= status_word;
      hw_protected_out <= hardware_protected_mode;
    end
  end

  // ==========================================================
  // Checks
  stat_zero_a: assert property (status_out[6:4] == 3'h0) else $error("status bits 6..4 not zero");
  sw_start_a: assert property (sw_go |=> busy_r ##1 busy_r) else $error("status cycle did not start");
  sw_guard_a: assert property (sw_go |-> wel_r && !(swd_r && !wp_q[1])) else $error("status write let through");
  wel_drop_a: assert property (done && !write_enable_instr_go |=> !wel_r) else $error("enable latch kept after cycle");
  bp_frozen_a: assert property (busy_r && !done |=> $stable(bp_r) && $stable(swd_r)) else $error("protection changed early");
  rd_ignore_a: assert property (byte_ev && state_r == ST_CMD && byte_r == CMD_ARRAY_READ && busy_r
    |=> state_r == ST_IGNORE) else $error("read taken while busy");
  page_wrap_a: assert property (wbyte |=> idx_r == 8'($past(idx_r) + 8'h01)) else $error("page index step wrong");
  aw_guard_a: assert property (aw_go |-> wel_r && !busy_r && !zone_hit && aligned) else $error("array write let through");
  erase_first_a: assert property (mem_r.we && !walk_r[9] && walk_r[8:0] <= 9'h100 && busy_r
    && kind_arr_r && $past(walk_r[8]) == 1'b0 |-> mem_r.wdata == ERASED_BYTE) else $error("program before erase");
  rd_step_a: assert property (byte_ev && state_r == ST_RDATA |=> cur_r == 17'($past(cur_r) + 17'h0_0001))
    else $error("read address step wrong");

endmodule // spi_eeprom_ctrl

// >>> spi_host_model.sv
// Behavioural serial bus host that frames instructions for the EEPROM block
`timescale 1ns/1ps
module spi_host_model (
  input wire logic clock_in,
  output logic spi_clk_out,
  output logic cs_n_out,
  output logic mosi_out,
  input wire logic miso_in,
  input wire logic miso_oe_in
);
  // ==========================================================
  // Idle bus: clock parked low, select high
  initial begin
    spi_clk_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end

  // ==========================================================
  // One frame, bits MSB first from the top of tx; rx bit i is taken at rising edge i
  // Off-boundary lengths are allowed on purpose so refusals can be provoked
  task automatic frame(input logic [63:0] tx, input int nbits, output logic [63:0] rx, output logic oe_seen);
    rx = '0;
    oe_seen = 1'b0;
    @(posedge clock_in);
    #1 cs_n_out = 1'b0;
    #33;
    for (int i = 0; i < nbits; i++) begin
      mosi_out = tx[63-i];
      #40 spi_clk_out = 1'b1;
      rx[63-i] = miso_in;
      oe_seen = oe_seen | miso_oe_in;
      #40 spi_clk_out = 1'b0;
    end
    // Select rises after the last rising edge, before any further one
    #20;
    @(posedge clock_in);
    #1 cs_n_out = 1'b1;
    mosi_out = ~mosi_out;
    // Gap long enough for the system clock side to see the deselect
    repeat (8) @(posedge clock_in);
  endtask
endmodule // spi_host_model

// >>> tb.sv
// Self-checking bench for the serial EEPROM instruction engine
`timescale 1ns/1ps
module tb;
  import eeprom_pkg::*;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic wp_n_in = 1'b1;
  logic spi_clk, cs_n, mosi, miso, miso_oe, hw_prot, oe;
  logic [7:0] status, mem_rdata, exp_b;
  logic [63:0] rx;
  mem_req_t mem_req;
  logic [7:0] mem [0:131071];
  logic [16:0] pa [0:2];
  int failures = 0;
  int checked = 0;

  // ==========================================================
  // Clock, combinational-read array model
  always #5 clock_in = ~clock_in;
  assign mem_rdata = mem[mem_req.addr];
  always @(posedge clock_in) begin
    if (mem_req.we === 1'b1) mem[mem_req.addr] <= mem_req.wdata;
  end

  spi_eeprom_ctrl #(.STATUS_CYCLES(600), .ARRAY_CYCLES(600)) u_dut (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .spi_clk_in(spi_clk), .cs_n_in(cs_n), .mosi_in(mosi),
    .wp_n_in(wp_n_in), .mem_rdata_in(mem_rdata), .miso_out(miso), .miso_oe_out(miso_oe),
    .mem_req_out(mem_req), .status_out(status), .hw_protected_out(hw_prot));

  spi_host_model u_host (.clock_in(clock_in), .spi_clk_out(spi_clk), .cs_n_out(cs_n), .mosi_out(mosi),
    .miso_in(miso), .miso_oe_in(miso_oe));

  // ==========================================================
  // Verdict and comparison helpers
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic [63:0] tx, input int nbits);
    u_host.frame(tx, nbits, rx, oe);
  endtask

  // Ends just after an edge, so registered outputs are read once settled
  task automatic settle();
    repeat (12) @(posedge clock_in);
    #1;
  endtask

  // Bounded poll until the busy flag drops; a hang counts as a mismatch
  task automatic wait_idle();
    int n;
    n = 0;
    settle();
    while (status[SR_WIP_BIT] !== 1'b0 && n < 3000) begin
      @(posedge clock_in);
      #1;
      n++;
    end
    if (n >= 3000) begin
      failures++;
      summarize();
    end
  endtask

  task automatic write_enable_instr();
    xfer({CMD_WRITE_ENABLE, 56'h0}, 8);
  endtask

  task automatic status_write_instr(input logic [7:0] v);
    write_enable_instr();
    xfer({CMD_STATUS_WRITE, v, 48'h0}, 16);
    wait_idle();
  endtask

  // Upper address bits set to junk; they must be ignored
  task automatic wr(input logic [16:0] a, input logic [7:0] d, input int nbits);
    xfer({CMD_ARRAY_WRITE, 7'h55, a, d, 24'h0}, nbits);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    for (int i = 0; i < 131072; i++) mem[i] = 8'hff;
    pa[0] = 17'h0_4000;
    pa[1] = 17'h1_4000;
    pa[2] = 17'h1_c000;
    repeat (12) @(posedge clock_in);
    #1 rst_n_in = 1'b1;
    settle();
    check(status, 8'h00);
    // Status write without the enable latch is dropped
    xfer({CMD_STATUS_WRITE, 8'h0c, 48'h0}, 16);
    settle();
    check(status, 8'h00);
    write_enable_instr();
    settle();
    check(status, 8'h02);
    // Disable instruction drops the latch again
    xfer({CMD_WRITE_DISABLE, 56'h0}, 8);
    settle();
    check(status, 8'h00);
    write_enable_instr();
    xfer({CMD_STATUS_WRITE, 8'h7f, 48'h0}, 16);
    settle();
    check({7'h0, status[SR_WIP_BIT]}, 8'h01);
    xfer({CMD_STATUS_READ, 56'h0}, 16);
    check(rx[55:48], 8'h03);
    wait_idle();
    check(status, 8'h0c);
    // Disable bit low: pin level does not matter
    wp_n_in = 1'b0;
    status_write_instr(8'h04);
    check(status, 8'h04);
    write_enable_instr();
    xfer({CMD_STATUS_WRITE, 8'h00, 48'h0}, 17);
    settle();
    check(status, 8'h06);
    // Disable bit set while the pin is already low
    status_write_instr(8'h88);
    check(status, 8'h88);
    check({7'h0, hw_prot}, 8'h01);
    wp_n_in = 1'b1;
    settle();
    check({7'h0, hw_prot}, 8'h00);
    // Pin lowered after the disable bit was set
    wp_n_in = 1'b0;
    settle();
    check({7'h0, hw_prot}, 8'h01);
    write_enable_instr();
    xfer({CMD_STATUS_WRITE, 8'h00, 48'h0}, 16);
    settle();
    check(status, 8'h8a);
    wp_n_in = 1'b1;
    settle();
    check({7'h0, hw_prot}, 8'h00);
    xfer({CMD_STATUS_WRITE, 8'h00, 48'h0}, 16);
    wait_idle();
    check(status, 8'h00);
    // Page write that runs past the page end, read refused while busy
    write_enable_instr();
    xfer({CMD_ARRAY_WRITE, 8'hfe, 8'h01, 8'hfe, 8'haa, 8'hbb, 8'hcc, 8'h00}, 56);
    xfer({CMD_ARRAY_READ, 56'h0}, 48);
    check({7'h0, oe}, 8'h00);
    wait_idle();
    check(status, 8'h00);
    xfer({CMD_ARRAY_READ, 8'hfe, 8'h01, 8'hfe, 32'h0}, 48);
    check(rx[31:24], 8'haa);
    check(rx[23:16], 8'hbb);
    xfer({CMD_ARRAY_READ, 8'h00, 8'h01, 8'h00, 32'h0}, 44);
    check(rx[31:24], 8'hcc);
    check({7'h0, miso_oe}, 8'h00);
    // Sequential read across the top of the array
    mem[17'h1_ffff] = 8'h5a;
    mem[17'h0_0000] = 8'ha5;
    xfer({CMD_ARRAY_READ, 8'hff, 8'hff, 8'hff, 32'h0}, 48);
    check(rx[31:24], 8'h5a);
    check(rx[23:16], 8'ha5);
    // Refused writes: no latch, then off a byte boundary
    wr(17'h0_0200, 8'h11, 40);
    settle();
    check(status, 8'h00);
    write_enable_instr();
    wr(17'h0_0200, 8'h11, 45);
    settle();
    check(status, 8'h02);
    check(mem[17'h0_0200], 8'hff);
    // Widest zone first, so a refused address still holds its delivery value
    for (int bp = 3; bp >= 0; bp--) begin
      status_write_instr(8'(bp << 2));
      for (int j = 0; j < 3; j++) begin
        write_enable_instr();
        wr(pa[j], 8'(bp * 16 + j), 40);
        wait_idle();
        exp_b = ((bp == 3) || (bp == 2 && j > 0) || (bp == 1 && j == 2)) ? 8'hff : 8'(bp * 16 + j);
        check(mem[pa[j]], exp_b);
      end
    end
    summarize();
  end
endmodule // tb
